// File: shared/wdt_defs.vh
// Purpose: constants for the windowed watchdog core
// Assumes: 32-bit tick counter, 8-bit feed writes
// Notes:   included by rtl/windowed_watchdog_core.v and rtl/sync_pulse.v
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH
`define WDT_CNT_W        32
`define WDT_CNT_RESET    32'h0000_0000
`define WDT_FEED_KEY1    8'ha5
`define WDT_FEED_KEY2    8'h5a
`define WDT_READY_DELAY  4'h2
`define WDT_SRST_CYCLES  8'h08
`endif

// File: rtl/sync_pulse.v
// Purpose: two-flop synchroniser with rising-edge pulse output
// Assumes: async input, clk domain output
// Notes:   first flop is read only by the second flop
`include "wdt_defs.vh"
module sync_pulse (
    // clock and reset
    input  wire clk,
    input  wire nrst,
    // async level in
    input  wire din,
    // synchronised level and its rising edge
    output wire level,
    output wire rise
);
    reg meta_reg;
    reg sync_reg;
    reg last_reg;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
endmodule

// File: rtl/windowed_watchdog_core.v
// Purpose: windowed watchdog with feed sequence, early and late events
// Assumes: nrst is power-on reset; sys_rst_n_in is the system reset; wdt_clk_in
//          is the selected watchdog clock, slower than clk, sampled via sync
// Notes:   control bits are plain ports; flags clear by a write pulse with value 0
// Notes on behaviour
// - count up each watchdog clock period when enabled
// - feed pair a5 then 5a clears counter
// - no time limit between the two feed writes
// - count at late interrupt threshold sets flag, irq
// - count at late reset threshold sets flag, reset
// - watchdog system reset clears counter, keeps enable, flags
// - window feed below early reset threshold: reset flag
// - window feed in early interrupt band: interrupt flag
// - flags set regardless of interrupt/reset enables and window mode; no events while timer disabled
// - clock ready rising is enabled event, no flag
// - interrupt enable and reset enable gate independently
// - counting continues during sleep
// - system reset keeps enable and event flags
// - enable change drops ready until change done
// - flags sticky until software writes zero
// - window off: only late events act
`include "wdt_defs.vh"
module windowed_watchdog_core #(
    parameter CNT_W = `WDT_CNT_W
) (
    // clock and power-on reset
    input  wire             clk,
    input  wire             nrst,
    // system reset from the reset controller, active low, synchronised here by two flops
    input  wire             sys_rst_n_in,
    // selected watchdog clock
    input  wire             wdt_clk_in,
    // feed writes
    input  wire             feed_wr,
    input  wire [7:0]       feed_data,
    // control bits
    input  wire             timer_en,
    input  wire             win_en,
    input  wire             int_en,
    input  wire             rst_en,
    input  wire [CNT_W-1:0] int_late_val,
    input  wire [CNT_W-1:0] rst_late_val,
    input  wire [CNT_W-1:0] int_early_val,
    input  wire [CNT_W-1:0] rst_early_val,
    // flag writes: a pulse with a mask, 0 clears a flag and 1 keeps it
    input  wire             flag_wr,
    input  wire [3:0]       flag_wdata,
    // status
    output reg  [CNT_W-1:0] tick_counter,
    output reg  [3:0]       flags,
    output reg              clk_ready,
    output reg              ready_event,
    output reg              wdt_irq,
    output reg              sys_irq,
    output reg              sys_rst_req
);
    // flags: 3 rst_late, 2 rst_early, 1 int_late, 0 int_early
    localparam F_IE = 0;
    localparam F_IL = 1;
    localparam F_RE = 2;
    localparam F_RL = 3;
    localparam S_IDLE = 2'b01;
    localparam S_KEY1 = 2'b10;

    wire       tick;
    wire       sys_rst_lvl;
    reg  [1:0] feed_state_reg;
    reg  [1:0] feed_state_next;
    reg        feed_done;
    reg        en_seen_reg;
    reg  [3:0] rdy_cnt_reg;
    reg        srst_q1_reg;
    reg        srst_q2_reg;
    reg  [7:0] srst_cnt_reg;
    reg  [3:0] ev;
    wire       in_sys_rst;
    reg  [CNT_W-1:0] counter_next;
    reg  [3:0]       flags_next;
    reg  [7:0]       srst_cnt_next;
    reg  [3:0]       rdy_cnt_next;
    reg              clk_ready_next;
    reg              ready_event_next;
    reg              rst_ev_any;
    reg              wdt_irq_next;
    reg              sys_irq_next;
    reg              sys_rst_next;

    sync_pulse u_tick (
        .clk   (clk),
        .nrst  (nrst),
        .din   (wdt_clk_in),
        .level (),
        .rise  (tick)
    );

    // system reset input sync (level only)
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            srst_q1_reg <= 1'b0;
            srst_q2_reg <= 1'b0;
        end else begin
            srst_q1_reg <= ~sys_rst_n_in;
            srst_q2_reg <= srst_q1_reg;
        end
    end
    assign sys_rst_lvl = srst_q2_reg;
    assign in_sys_rst  = sys_rst_lvl | (srst_cnt_reg != 8'h00);

    // feed sequence recogniser
    always @* begin
        feed_state_next = feed_state_reg;
        feed_done       = 1'b0;
        if (feed_wr) begin
            case (feed_state_reg)
                S_IDLE: begin
                    if (feed_data == `WDT_FEED_KEY1)
                        feed_state_next = S_KEY1;
                end
                S_KEY1: begin
                    if (feed_data == `WDT_FEED_KEY2) begin
                        feed_done       = 1'b1;
                        feed_state_next = S_IDLE;
                    end else if (feed_data != `WDT_FEED_KEY1) begin
                        feed_state_next = S_IDLE;
                    end
                end
                default: feed_state_next = S_IDLE;
            endcase
        end
    end

    // event detection
    always @* begin
        ev = 4'h0;
        if (timer_en && tick && !in_sys_rst) begin
            ev[F_IL] = (tick_counter == int_late_val);
            ev[F_RL] = (tick_counter == rst_late_val);
        end
        // a disabled watchdog does not judge feed timing
        if (feed_done && timer_en) begin
            ev[F_RE] = (tick_counter < rst_early_val);
            ev[F_IE] = (tick_counter >= rst_early_val) &&
                       (tick_counter < int_early_val);
        end
    end

    // wdt_irq gated by int_en, sys_rst_req by rst_en, sys_irq by neither; early events by window mode
    always @* begin
        rst_ev_any   = ev[F_RL] || (win_en && ev[F_RE]);
        wdt_irq_next = int_en && (ev[F_IL] || (win_en && ev[F_IE]));
        sys_irq_next = rst_ev_any;
        sys_rst_next = rst_en && rst_ev_any;
    end

    // counter; sleep has no effect here, enable and system reset gate it
    always @* begin
        counter_next = tick_counter;
        if (in_sys_rst)
            counter_next = `WDT_CNT_RESET;
        else if (feed_done)
            counter_next = `WDT_CNT_RESET;
        else if (timer_en && tick)
            counter_next = tick_counter + 1'b1;
    end

    // sticky flags, set wins over software clear; no sys reset here
    always @* begin
        if (flag_wr)
            flags_next = (flags & flag_wdata) | ev;
        else
            flags_next = flags | ev;
    end

    // hold off counting for a while after our own reset request
    always @* begin
        srst_cnt_next = srst_cnt_reg;
        if (sys_rst_next)
            srst_cnt_next = `WDT_SRST_CYCLES;
        else if (srst_cnt_reg != 8'h00)
            srst_cnt_next = srst_cnt_reg - 8'h01;
    end

    // clock ready handshake on enable change
    always @* begin
        rdy_cnt_next     = rdy_cnt_reg;
        clk_ready_next   = clk_ready;
        ready_event_next = 1'b0;
        if (timer_en != en_seen_reg) begin
            clk_ready_next = 1'b0;
            rdy_cnt_next   = `WDT_READY_DELAY;
        end else if (rdy_cnt_reg != 4'h0) begin
            rdy_cnt_next = rdy_cnt_reg - 4'h1;
        end else if (!clk_ready) begin
            clk_ready_next   = 1'b1;
            ready_event_next = 1'b1;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            feed_state_reg <= S_IDLE;
            tick_counter   <= `WDT_CNT_RESET;
            flags          <= 4'h0;
            en_seen_reg    <= 1'b0;
            rdy_cnt_reg    <= 4'h0;
            clk_ready      <= 1'b0;
            ready_event    <= 1'b0;
            wdt_irq        <= 1'b0;
            sys_irq        <= 1'b0;
            sys_rst_req    <= 1'b0;
            srst_cnt_reg   <= 8'h00;
        end else begin
            feed_state_reg <= feed_state_next;
            tick_counter   <= counter_next;
            flags          <= flags_next;
            en_seen_reg    <= timer_en;
            rdy_cnt_reg    <= rdy_cnt_next;
            clk_ready      <= clk_ready_next;
            ready_event    <= ready_event_next;
            wdt_irq        <= wdt_irq_next;
            sys_irq        <= sys_irq_next;
            sys_rst_req    <= sys_rst_next;
            srst_cnt_reg   <= srst_cnt_next;
        end
    end
endmodule

// File: testbench/wdt_monitor.sv
// Purpose: port checker for the watchdog core
// Assumes: single clock, nrst is the power-on reset
// Notes:   bound from the bench top
module wdt_monitor #(parameter CNT_W = 32) (
    // clock, reset, writes and enables
    input wire             clk, nrst, feed_wr, int_en, rst_en, flag_wr,
    input wire [7:0]       feed_data,
    // status
    input wire [CNT_W-1:0] tick_counter,
    input wire [3:0]       flags,
    input wire             clk_ready, ready_event, wdt_irq, sys_irq, sys_rst_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ready_pulse_a: assert property (ready_event |-> clk_ready) else $error("ready pulse");
    ready_rise_a: assert property ($rose(clk_ready) |-> ready_event) else $error("ready rise");
    irq_gate_a: assert property (wdt_irq |-> $past(int_en)) else $error("irq gate");
    rst_gate_a: assert property (sys_rst_req |-> $past(rst_en)) else $error("rst gate");
    irq_flag_a: assert property (wdt_irq |-> flags[1] || flags[0]) else $error("irq flag");
    rst_flag_a: assert property (sys_rst_req |-> flags[3] || flags[2]) else $error("rst flag");
    sys_irq_a: assert property (sys_rst_req |-> sys_irq) else $error("sys irq");
    flag_hold_a: assert property (!$past(flag_wr) |-> (flags & $past(flags)) == $past(flags))
        else $error("flag lost");
    feed_clear_a: assert property (feed_wr && feed_data == 8'h5a && $past(feed_wr)
        && $past(feed_data) == 8'ha5 |=> tick_counter == '0) else $error("feed");
endmodule

// File: testbench/tb_windowed_watchdog_core.sv
// Purpose: self-checking bench for the watchdog core
// Assumes: watchdog clock driven by hand, 8 clk per tick
// Notes:   pulse outputs are counted as they occur
module tb_windowed_watchdog_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, nrst = 0, srn = 1, wk = 0, fw = 0, flw = 0, te = 0, we = 0;
    logic        ie = 1, re = 1;
    logic [7:0]  fd = 8'h00;
    logic [3:0]  fwd = 4'hf;
    logic [31:0] il = 32'h2, rl = 32'h5, iev = 32'h4, rev = 32'h2;
    wire  [31:0] cnt;
    wire  [3:0]  fl;
    wire         rdy, rdy_ev, irq, sirq, srq;
    int          fails = 0, compares = 0, irqs = 0, rsts = 0, rdys = 0, sirqs = 0;
    windowed_watchdog_core u_dut (.clk(clk), .nrst(nrst), .sys_rst_n_in(srn), .wdt_clk_in(wk),
        .feed_wr(fw), .feed_data(fd), .timer_en(te), .win_en(we), .int_en(ie), .rst_en(re),
        .int_late_val(il), .rst_late_val(rl), .int_early_val(iev), .rst_early_val(rev),
        .flag_wr(flw), .flag_wdata(fwd), .tick_counter(cnt), .flags(fl), .clk_ready(rdy),
        .ready_event(rdy_ev), .wdt_irq(irq), .sys_irq(sirq), .sys_rst_req(srq));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        irqs <= irqs + irq;
        rsts <= rsts + srq;
        rdys <= rdys + rdy_ev;
        sirqs <= sirqs + sirq;
    end
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        close_out;
    end
    task chk(input logic ok);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task tick(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk) wk <= 1;
            repeat (4) @(posedge clk) wk <= 0;
        end
    endtask
    task key(input logic [7:0] a, b, input logic [3:0] m = 4'hf);
        @(posedge clk) fw <= 1;
        fd <= a;
        flw <= 1;
        fwd <= m;
        @(posedge clk) fd <= b;
        flw <= 0;
        @(posedge clk) fw <= 0;
        repeat (2) @(posedge clk);
    endtask
    task close_out;
        if (fails == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task t_count;
        tick(1);
        key(8'ha5, 8'h33);
        key(8'h5a, 8'h5a);
        chk(cnt === 32'h1);
        key(8'h33, 8'ha5);
        tick(1);
        key(8'h5a, 8'h33);
        chk(cnt === 32'h0 && fl === 4'h1 && irqs == 0 && rsts == 0);
    endtask
    task t_late;
        tick(3);
        chk(fl === 4'h3 && irqs == 1);
        key(8'h33, 8'h33, 4'h0);
        chk(fl === 4'h0);
        tick(3);
        chk(fl === 4'h8 && rsts == 1 && irqs == 1 && sirqs == 1);
        srn <= 0;
        repeat (4) @(posedge clk);
        srn <= 1;
        repeat (12) @(posedge clk);
        chk(cnt === 32'h0 && fl === 4'h8);
    endtask
    task t_early;
        we <= 1;
        key(8'ha5, 8'h5a, 4'h0);
        chk(fl === 4'h4 && rsts == 2 && sirqs == 2);
        repeat (10) @(posedge clk);
        tick(2);
        key(8'ha5, 8'h5a, 4'h0);
        chk(cnt === 32'h0 && fl === 4'h1 && irqs == 2 && rsts == 2);
    endtask
    task t_long;
        re <= 0;
        we <= 0;
        key(8'ha5, 8'h5a, 4'h0);
        chk(fl === 4'h4 && rsts == 2 && sirqs == 2);
        tick(6);
        chk(cnt === 32'h6 && fl === 4'he && irqs == 3 && sirqs == 3 && rsts == 2);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1;
        key(8'ha5, 8'h5a, 4'h0);
        te <= 1;
        repeat (2) @(posedge clk);
        chk(rdy === 1'b0);
        repeat (10) @(posedge clk);
        chk(rdy === 1'b1 && fl === 4'h0 && cnt === 32'h0 && rdys == 2);
        t_count;
        t_late;
        t_early;
        t_long;
        close_out;
    end
endmodule
bind windowed_watchdog_core wdt_monitor #(.CNT_W(CNT_W)) u_mon (.clk(clk), .nrst(nrst),
    .feed_wr(feed_wr), .int_en(int_en), .rst_en(rst_en), .flag_wr(flag_wr), .flags(flags),
    .feed_data(feed_data), .tick_counter(tick_counter), .clk_ready(clk_ready),
    .ready_event(ready_event), .wdt_irq(wdt_irq), .sys_irq(sys_irq), .sys_rst_req(sys_rst_req));
